// >>> rffp_filter.sv
// Receive frame pattern filter with fixed and port-set destination address checks
//
// Notes on behaviour
// - Check destination address: pause, broadcast, unicast, multicast pause.
// - Address results go out to flow control and statistics.
// - Each filter holds a 512-bit pattern, bit 0 first received.
// - Mask bit one compares that bit; zero makes it don't-care.
// - Eight general filters plus three bridging filters.
// - Pattern and mask reached by 32 shared words; selector picks filter.
// - Per-filter verdict bus, bridging filters excluded.
// - Promiscuous marks every good frame good, else only matching frames.
// - Each filter has an enable; disabled filter never matches.
// - General filters reset to ones in low 48 pattern and mask bits.
// - Verdict bit high means drop: its filter did not match.
// - Extra top verdict bit is set when any general filter matched.
// - Verdict bits behave the same in promiscuous mode.
// - With bridging select, low two index bits pick; index three ignored.
// - Bridging index one is class A, index two class B.
// - Class A and class B matches are ORed into one result.
// - Bridging filters reset to timing and both class frames.
// - Class filters reset to type 0x0081, tags 0x0260 and 0x0240.
// - Modes and enables come from static ports; pattern and mask go through the cfg word window.
`timescale 1ns/1ps
`default_nettype none
module rffp_filter (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic promiscuous,
  input wire logic [47:0] unicast_addr,
  input wire logic [47:0] pause_addr,
  input wire logic [7:0] filt_enable,
  input wire logic [2:0] avb_filt_enable,
  input wire logic bridging_filter_select,
  input wire logic [2:0] filt_index,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [4:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_good,
  output logic [7:0] out_data,
  output logic out_valid,
  output logic out_last,
  output logic out_good,
  output logic [8:0] out_tuser,
  output logic out_av_match,
  output logic out_ptp_match,
  output logic da_pause,
  output logic da_bcast,
  output logic da_ucast,
  output logic da_mc_pause,
  output logic da_valid
);

  // ----------------------------------------------------------
  // Functions
  // ----------------------------------------------------------
  // Masked byte compare
  function automatic logic byte_ok(
    input logic [7:0] d,
    input logic [7:0] p,
    input logic [7:0] m
  );
    byte_ok = ((d ^ p) & m) == 8'h00;
  endfunction : byte_ok

  function automatic logic [7:0] addr_byte(
    input logic [47:0] a,
    input logic [2:0] i
  );
    addr_byte = a[{i, 3'b000} +: 8];
  endfunction : addr_byte

  function automatic logic [31:0] rst_word(
    input int s,
    input int w,
    input logic is_mask
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    if (s < rffp_pkg::NUM_GEN) begin
      if (w == 0) begin
        v = rffp_pkg::GEN_RST_W0;
      end else if (w == 1) begin
        v = rffp_pkg::GEN_RST_W1;
      end
    end else if (w == rffp_pkg::AV_WORD) begin
      if (s == rffp_pkg::NUM_GEN) begin
        v = is_mask ? rffp_pkg::PTP_RST_MASK : rffp_pkg::PTP_RST_PAT;
      end else if (s == rffp_pkg::NUM_GEN + 1) begin
        v = is_mask ? rffp_pkg::CLASS_RST_MASK
                    : rffp_pkg::CLASS_A_RST_PAT;
      end else begin
        v = is_mask ? rffp_pkg::CLASS_RST_MASK
                    : rffp_pkg::CLASS_B_RST_PAT;
      end
    end
    rst_word = v;
  endfunction : rst_word

  // ----------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------
  // Filter selection and storage
  // ----------------------------------------------------------
  logic [31:0] pat [rffp_pkg::NUM_SLOT][rffp_pkg::NUM_WORD];
  logic [31:0] msk [rffp_pkg::NUM_SLOT][rffp_pkg::NUM_WORD];

  wire logic sel_ok;
  wire logic cfg_take;
  wire logic pick_mask;
  wire logic [3:0] sel_slot;
  wire logic [3:0] cfg_word;
  wire logic [31:0] rd_word;

  // Index three in bridging space selects nothing
  assign sel_ok = !bridging_filter_select ||
                  (filt_index[1:0] != rffp_pkg::AVB_BAD_IDX);
  // One shared word window, steered by the selector
  assign sel_slot = bridging_filter_select ?
                    rffp_pkg::AVB_BASE + {2'b00, filt_index[1:0]} :
                    {1'b0, filt_index};
  assign cfg_word = cfg_addr[3:0];
  assign pick_mask = cfg_addr[4];
  // Writes to bridging index three are dropped
  assign cfg_take = ce && cfg_wr && sel_ok;
  assign rd_word = pick_mask ? msk[sel_slot][cfg_word]
                             : pat[sel_slot][cfg_word];

  // Writes land in whichever filter is selected now
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < rffp_pkg::NUM_SLOT; s++) begin
        for (int w = 0; w < rffp_pkg::NUM_WORD; w++) begin
          pat[s][w] <= rst_word(s, w, 1'b0);
          msk[s][w] <= rst_word(s, w, 1'b1);
        end
      end
    end else if (cfg_take) begin
      if (pick_mask) begin
        msk[sel_slot][cfg_word] <= cfg_wdata;
      end else begin
        pat[sel_slot][cfg_word] <= cfg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= sel_ok ? rd_word : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------
  // Byte position within the frame
  // ----------------------------------------------------------
  logic [6:0] cnt;
  wire logic first;
  wire logic in_pat;
  wire logic in_da;
  wire logic [3:0] wi;
  wire logic [1:0] lane;
  wire logic beat;
  wire logic frame_end;

  assign beat = ce && rx_valid;
  // Final byte of a frame taken
  assign frame_end = beat && rx_last;
  assign first = cnt == 7'h00;
  assign in_pat = cnt < 7'(rffp_pkg::PAT_BYTES);
  assign in_da = cnt < 7'(rffp_pkg::DA_BYTES);
  assign wi = cnt[5:2];
  assign lane = cnt[1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 7'h00;
    end else if (beat) begin
      if (rx_last) begin
        cnt <= 7'h00;
      end else if (in_pat) begin
        cnt <= cnt + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------
  // Pattern match, running per slot
  // ----------------------------------------------------------
  logic [rffp_pkg::NUM_SLOT-1:0] m_run;
  logic [rffp_pkg::NUM_SLOT-1:0] hit_now;

  // Byte n meets pattern bits 8n+7..8n
  always_comb begin
    logic [7:0] pb;
    logic [7:0] mb;
    pb = 8'h00;
    mb = 8'h00;
    for (int s = 0; s < rffp_pkg::NUM_SLOT; s++) begin
      pb = pat[s][wi][{lane, 3'b000} +: 8];
      mb = msk[s][wi][{lane, 3'b000} +: 8];
      hit_now[s] = (first || m_run[s]) &&
                   (!in_pat || byte_ok(rx_data, pb, mb));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_run <= '1;
    end else if (beat) begin
      m_run <= hit_now;
    end
  end

  // ----------------------------------------------------------
  // Destination address checks
  // ----------------------------------------------------------
  logic [3:0] da_run;
  wire logic [3:0] da_now;
  wire logic [3:0] da_cur;
  wire logic [2:0] di;

  assign di = cnt[2:0];
  assign da_cur = first ? 4'hF : da_run;
  assign da_now[0] = da_cur[0] && (!in_da ||
                     rx_data == addr_byte(pause_addr, di));
  assign da_now[1] = da_cur[1] && (!in_da ||
                     rx_data == addr_byte(rffp_pkg::BCAST_ADDR, di));
  assign da_now[2] = da_cur[2] && (!in_da ||
                     rx_data == addr_byte(unicast_addr, di));
  assign da_now[3] = da_cur[3] && (!in_da ||
                     rx_data == addr_byte(rffp_pkg::MC_PAUSE_ADDR, di));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      da_run <= 4'hF;
    end else if (beat) begin
      da_run <= da_now;
    end
  end

  // ----------------------------------------------------------
  // Verdicts
  // ----------------------------------------------------------
  wire logic [7:0] gen_hit;
  wire logic ptp_hit;
  wire logic av_hit;
  wire logic any_hit;
  wire logic frame_good;
  wire logic [8:0] tuser_now;

  assign gen_hit = hit_now[7:0] & filt_enable;
  assign ptp_hit = hit_now[8] && avb_filt_enable[0];
  assign av_hit = (hit_now[9] && avb_filt_enable[1]) ||
                  (hit_now[10] && avb_filt_enable[2]);
  assign any_hit = (|da_now) || (|gen_hit) || ptp_hit || av_hit;
  assign frame_good = rx_good && (promiscuous || any_hit);
  // Drop bit per general filter, catch-all on top
  assign tuser_now = {|gen_hit, ~gen_hit};

  // Stream delayed one beat so verdicts meet the last byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= 8'h00;
      out_valid <= 1'b0;
      out_last <= 1'b0;
    end else if (ce) begin
      out_valid <= rx_valid;
      out_last <= frame_end;
      if (rx_valid) begin
        out_data <= rx_data;
      end
    end
  end

  // Verdicts held from the final beat until the next one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_good <= 1'b0;
      out_tuser <= 9'h0FF;
      out_av_match <= 1'b0;
      out_ptp_match <= 1'b0;
    end else if (frame_end) begin
      out_good <= frame_good;
      out_tuser <= tuser_now;
      out_av_match <= av_hit;
      out_ptp_match <= ptp_hit;
    end
  end

  // Address results for flow control and statistics
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      da_pause <= 1'b0;
      da_bcast <= 1'b0;
      da_ucast <= 1'b0;
      da_mc_pause <= 1'b0;
      da_valid <= 1'b0;
    end else if (ce) begin
      da_valid <= frame_end;
      if (frame_end) begin
        da_pause <= da_now[0];
        da_bcast <= da_now[1];
        da_ucast <= da_now[2];
        da_mc_pause <= da_now[3];
      end
    end
  end

  // Modes and enables arrive on static ports; patterns via the cfg window
endmodule : rffp_filter
`default_nettype wire

// >>> rffp_pkg.sv
// Constants shared by the receive frame pattern filter
package rffp_pkg;
  // ------------------------------------------------------------
  // Filter counts and pattern geometry
  // ------------------------------------------------------------
  localparam int NUM_GEN = 8;
  localparam int NUM_AVB = 3;
  localparam int NUM_SLOT = NUM_GEN + NUM_AVB;
  localparam int NUM_WORD = 16;
  localparam int PAT_BYTES = 64;
  localparam int DA_BYTES = 6;
  localparam logic [3:0] AVB_BASE = 4'h8;
  localparam logic [1:0] AVB_PTP = 2'h0;
  localparam logic [1:0] AVB_CLASS_A = 2'h1;
  localparam logic [1:0] AVB_CLASS_B = 2'h2;
  localparam logic [1:0] AVB_BAD_IDX = 2'h3;
  // ------------------------------------------------------------
  // Fixed addresses, first byte on the wire in bits 7:0
  // ------------------------------------------------------------
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] MC_PAUSE_ADDR = 48'h0100_00C2_8001;
  // ------------------------------------------------------------
  // Reset contents, word n holds bytes 4n+3..4n
  // ------------------------------------------------------------
  localparam logic [31:0] GEN_RST_W0 = 32'hFFFF_FFFF;
  localparam logic [31:0] GEN_RST_W1 = 32'h0000_FFFF;
  localparam int AV_WORD = 3;
  localparam logic [31:0] PTP_RST_PAT = 32'h0000_F788;
  localparam logic [31:0] PTP_RST_MASK = 32'h0000_FFFF;
  localparam logic [31:0] CLASS_A_RST_PAT = 32'h0260_0081;
  localparam logic [31:0] CLASS_B_RST_PAT = 32'h0240_0081;
  localparam logic [31:0] CLASS_RST_MASK = 32'hFFFF_FFFF;
endpackage : rffp_pkg

// >>> rffp_properties.sv
// Port timing checker of the frame pattern filter
`timescale 1ns/1ps
`default_nettype none
module rffp_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic promiscuous,
  input wire logic [7:0] filt_enable,
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_good,
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  input wire logic out_last,
  input wire logic out_good,
  input wire logic [8:0] out_tuser,
  input wire logic da_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_byte; ce && rx_valid; endsequence
  sequence s_end; ce && rx_valid && rx_last; endsequence
  property p_rd; ce && cfg_rd |=> cfg_rvalid; endproperty
  property p_rv; cfg_rvalid |-> $past(cfg_rd); endproperty
  property p_data; s_byte |=> out_valid && out_data == $past(rx_data);
  endproperty
  property p_end; s_end |=> out_last && da_valid; endproperty
  property p_prom; s_end ##0 (promiscuous && rx_good) |=> out_good;
  endproperty
  property p_bad; s_end ##0 !rx_good |=> !out_good; endproperty
  property p_else;
    da_valid |-> out_tuser[8] == (out_tuser[7:0] != 8'hFF);
  endproperty
  property p_off; da_valid |-> &(out_tuser[7:0] | $past(filt_enable));
  endproperty
  property p_hold;
    !da_valid |-> $stable(out_tuser) && $stable(out_good);
  endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  a_rv: assert property (p_rv) else $error("stray read answer");
  a_data: assert property (p_data) else $error("byte not passed");
  a_end: assert property (p_end) else $error("frame end late");
  a_prom: assert property (p_prom) else $error("good frame lost");
  a_bad: assert property (p_bad) else $error("bad frame kept");
  a_else: assert property (p_else) else $error("catch-all wrong");
  a_off: assert property (p_off) else $error("disabled match");
  a_hold: assert property (p_hold) else $error("verdict moved");
endmodule : rffp_properties
bind rffp_filter rffp_properties u_prop (.clk(clk), .nrst(nrst), .ce(ce),
  .promiscuous(promiscuous), .filt_enable(filt_enable), .cfg_rd(cfg_rd),
  .cfg_rvalid(cfg_rvalid), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_last(rx_last), .rx_good(rx_good), .out_data(out_data),
  .out_valid(out_valid), .out_last(out_last), .out_good(out_good),
  .out_tuser(out_tuser), .da_valid(da_valid));
`default_nettype wire

// >>> rffp_fifo_model.sv
// Downstream per-filter FIFO model counting admitted frames
`timescale 1ns/1ps
`default_nettype none
module rffp_fifo_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic out_last,
  input wire logic out_good,
  input wire logic [8:0] out_tuser,
  output int taken
);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      taken <= 0;
    end else if (out_last && out_good) begin
      taken <= taken + $countones(~out_tuser);
    end
  end
endmodule : rffp_fifo_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the frame pattern filter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, nrst, ce, promiscuous, bridging_filter_select, cfg_wr, cfg_rd;
  logic [47:0] unicast_addr, pause_addr;
  logic [7:0] filt_enable, rx_data, out_data;
  logic [2:0] avb_filt_enable, filt_index;
  logic [4:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, lf;
  logic rx_valid, rx_last, rx_good, cfg_rvalid, out_valid, out_last;
  logic out_good, out_av_match, out_ptp_match, da_valid;
  logic da_pause, da_bcast, da_ucast, da_mc_pause;
  logic [8:0] out_tuser;
  logic [7:0] pat [11][64];
  logic [7:0] msk [11][64];
  logic [7:0] fq [$];
  int mismatches, compares, taken, exp_taken;
  rffp_filter i_dut (.clk(clk), .nrst(nrst), .ce(ce),
    .promiscuous(promiscuous), .unicast_addr(unicast_addr),
    .pause_addr(pause_addr), .filt_enable(filt_enable),
    .avb_filt_enable(avb_filt_enable), .filt_index(filt_index),
    .bridging_filter_select(bridging_filter_select), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_good(rx_good),
    .out_data(out_data), .out_valid(out_valid), .out_last(out_last),
    .out_good(out_good), .out_tuser(out_tuser), .out_av_match(out_av_match),
    .out_ptp_match(out_ptp_match), .da_pause(da_pause), .da_bcast(da_bcast),
    .da_ucast(da_ucast), .da_mc_pause(da_mc_pause), .da_valid(da_valid));
  rffp_fifo_model i_fifo (.clk(clk), .nrst(nrst), .out_last(out_last),
    .out_good(out_good), .out_tuser(out_tuser), .taken(taken));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #3_000_000;
    mismatches++;
    end_of_test();
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04C1_1DB7 : 32'h0);
    return lf;
  endfunction : rnd
  function automatic logic hit(input int s);
    for (int k = 0; k < fq.size() && k < 64; k++) begin
      if (((fq[k] ^ pat[s][k]) & msk[s][k]) != 8'h00) return 1'b0;
    end
    return 1'b1;
  endfunction : hit
  function automatic logic da(input logic [47:0] a);
    for (int k = 0; k < 6; k++) begin
      if (fq[k] != a[8*k+:8]) return 1'b0;
    end
    return 1'b1;
  endfunction : da
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic acc(input int s, input int a, input logic w,
    input logic [31:0] d);
    @(posedge clk);
    bridging_filter_select <= (s > 7);
    filt_index <= (s > 7) ? 3'(s - 8) : 3'(s);
    {cfg_wr, cfg_rd} <= {w, !w};
    cfg_addr <= 5'(a);
    cfg_wdata <= d;
    @(posedge clk);
    {cfg_wr, cfg_rd} <= 2'b00;
  endtask : acc
  task automatic rd_all();
    logic [31:0] e;
    for (int s = 0; s < 12; s++) begin
      for (int a = 0; a < 32; a++) begin
        for (int b = 0; b < 4; b++) begin
          e[8*b+:8] = (s > 10) ? 8'h00 : (a < 16) ? pat[s][4*a+b] :
            msk[s][4*a-64+b];
        end
        acc(s, a, 1'b0, 32'h0);
        #1;
        chk("rvalid", 32'(cfg_rvalid), 32'h1);
        chk("rdata", cfg_rdata, e);
      end
    end
  endtask : rd_all
  task automatic frame();
    int n, src, ds;
    logic [31:0] r;
    logic [8:0] tu;
    logic g, av, pt;
    logic [3:0] dx, dy;
    n = 12 + int'(rnd() % 70);
    src = int'(rnd() % 22);
    ds = int'(rnd() % 5);
    fq = {};
    for (int k = 0; k < n; k++) begin
      r = rnd();
      if (k < 6) r[7:0] = (ds == 0) ? 8'hFF : (ds == 1) ?
        unicast_addr[8*k+:8] : (ds == 2) ? pause_addr[8*k+:8] :
        (ds == 3) ? rffp_pkg::MC_PAUSE_ADDR[8*k+:8] : r[7:0];
      if (k < 64 && src < 11) r[7:0] = (pat[src][k] & msk[src][k]) |
        (r[7:0] & ~msk[src][k]);
      fq.push_back(r[7:0]);
    end
    @(posedge clk);
    r = rnd();
    promiscuous <= r[0];
    filt_enable <= r[15:8];
    avb_filt_enable <= r[18:16];
    rx_good <= (r[21:20] != 2'b00);
    foreach (fq[k]) begin
      {rx_valid, rx_last} <= {1'b1, k == n - 1};
      rx_data <= fq[k];
      @(posedge clk);
    end
    {rx_valid, rx_last} <= 2'b00;
    #1;
    tu = 9'h0FF;
    for (int i = 0; i < 8; i++) if (filt_enable[i] && hit(i)) tu[i] = 1'b0;
    tu[8] = (tu[7:0] != 8'hFF);
    av = (avb_filt_enable[1] && hit(9)) || (avb_filt_enable[2] && hit(10));
    pt = avb_filt_enable[0] && hit(8);
    g = rx_good && (promiscuous || tu[8] || av || pt || da(48'hFFFF_FFFF_FFFF)
      || da(unicast_addr) || da(pause_addr) || da(rffp_pkg::MC_PAUSE_ADDR));
    if (g) exp_taken += $countones(~tu);
    chk("tuser", 32'(out_tuser), 32'(tu));
    chk("good", 32'(out_good), 32'(g));
    chk("av ptp", 32'({out_av_match, out_ptp_match}), 32'({av, pt}));
    dx = {da(pause_addr), da(48'hFFFF_FFFF_FFFF), da(unicast_addr),
      da(rffp_pkg::MC_PAUSE_ADDR)};
    dy = {da_pause, da_bcast, da_ucast, da_mc_pause};
    chk("da", 32'(dy), 32'(dx));
  endtask : frame
  initial begin
    lf = 32'hEDC6_B126;
    nrst = 1'b0;
    {promiscuous, bridging_filter_select, cfg_wr, cfg_rd} = 4'h0;
    ce = 1'b1;
    {rx_valid, rx_last, rx_good, rx_data, filt_index, cfg_addr} = '0;
    {filt_enable, avb_filt_enable, cfg_wdata} = '0;
    unicast_addr = 48'({rnd(), rnd()});
    pause_addr = 48'({rnd(), rnd()});
    foreach (pat[s, k]) pat[s][k] = (s < 8 && k < 6) ? 8'hFF : 8'h00;
    msk = pat;
    for (int b = 0; b < 4; b++) begin
      pat[8][12+b] = rffp_pkg::PTP_RST_PAT[8*b+:8];
      msk[8][12+b] = rffp_pkg::PTP_RST_MASK[8*b+:8];
      pat[9][12+b] = rffp_pkg::CLASS_A_RST_PAT[8*b+:8];
      pat[10][12+b] = rffp_pkg::CLASS_B_RST_PAT[8*b+:8];
      msk[9][12+b] = 8'hFF;
      msk[10][12+b] = 8'hFF;
    end
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rd_all();
    repeat (60) frame();
    @(posedge clk);
    {filt_enable, avb_filt_enable} <= '0;
    for (int s = 0; s < 12; s++) begin
      for (int a = 0; a < 32; a++) begin
        r_w(s, a);
      end
    end
    // Clock enable low drops a write
    ce <= 1'b0;
    acc(0, 0, 1'b1, ~rnd());
    ce <= 1'b1;
    rd_all();
    repeat (150) frame();
    repeat (2) @(posedge clk);
    #1;
    chk("taken", 32'(taken), 32'(exp_taken));
    end_of_test();
  end
  task automatic r_w(input int s, input int a);
    logic [31:0] d;
    d = (a < 20) ? rnd() : 32'h0;
    acc(s, a, 1'b1, d);
    for (int b = 0; b < 4 && s < 11; b++) begin
      if (a < 16) pat[s][4*a+b] = d[8*b+:8];
      else msk[s][4*a-64+b] = d[8*b+:8];
    end
  endtask : r_w
endmodule : testbench
`default_nettype wire
